// ### shared/sbd_pkg.sv
// Shared constants, types and helpers for the service access bus decoder
package sbd_pkg;

  // ==========================================================================
  // Address space
  // ==========================================================================
  localparam int ADDR_W = 36;
  localparam int SLV_ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CODE_HI = 35;
  localparam int CODE_LO = 32;
  localparam int BE_W = 4;

  // Slave codes carried in the top four address bits
  localparam logic [3:0] CODE_UNALLOC = 4'h0;
  localparam logic [3:0] CODE_OCD = 4'h1;
  localparam logic [3:0] CODE_HSB = 4'h4;
  localparam logic [3:0] CODE_HSB_ALT = 4'h5;
  localparam logic [3:0] CODE_MSU = 4'h6;

  // One-hot select positions towards the slaves
  localparam int SEL_W = 3;
  localparam int SEL_OCD = 0;
  localparam int SEL_HSB = 1;
  localparam int SEL_MSU = 2;

  // Debug port indices
  localparam int N_PORTS = 2;
  localparam int PORT_JTAG = 0;
  localparam int PORT_SWD = 1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 50;
  localparam int WAKE_HOLD_NS = 2000;
  localparam int WAKE_HOLD_CYC = (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 6;
  localparam logic [WAKE_CNT_W-1:0] WAKE_HOLD_CNT = WAKE_CNT_W'(WAKE_HOLD_CYC);

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_RSVD = 2'h3
  } sbd_size_t;

  typedef enum logic [1:0] {SLV_NONE, SLV_OCD, SLV_HSB, SLV_MSU} sbd_slave_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_CLK, ST_ACCESS} sbd_state_t;

  // Request as presented by one debug port, held stable until acknowledged
  typedef struct packed {
    logic req_tgl;
    logic write;
    sbd_size_t size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sbd_dbg_req_t;

  localparam int REQ_W = $bits(sbd_dbg_req_t);
  localparam int SYNC_W = REQ_W + 1;

  typedef struct packed {
    logic ack_tgl;
    logic err;
    logic [DATA_W-1:0] rdata;
  } sbd_dbg_rsp_t;

  // Shared request towards the three slaves
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic valid;
    logic write;
    logic alt_map;
    sbd_size_t size;
    logic [BE_W-1:0] be;
    logic [SLV_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sbd_slv_req_t;

  typedef struct packed {
    logic ready;
    logic err;
    logic [DATA_W-1:0] rdata;
  } sbd_slv_rsp_t;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic sbd_aligned(input sbd_size_t size, input logic [1:0] lo);
    case (size)
      SZ_BYTE: sbd_aligned = 1'b1;
      SZ_HALF: sbd_aligned = (lo[0] == 1'b0);
      SZ_WORD: sbd_aligned = (lo == 2'h0);
      default: sbd_aligned = 1'b0;
    endcase
  endfunction

  function automatic logic [BE_W-1:0] sbd_byte_en(input sbd_size_t size, input logic [1:0] lo);
    case (size)
      SZ_BYTE: sbd_byte_en = 4'h1 << lo;
      SZ_HALF: sbd_byte_en = lo[1] ? 4'hc : 4'h3;
      SZ_WORD: sbd_byte_en = 4'hf;
      default: sbd_byte_en = 4'h0;
    endcase
  endfunction

endpackage

// ### logic/sbd_sync.sv
// Three-stage synchroniser with agreement filter for inputs from outside the clock domain
`timescale 1ns/1ns
module sbd_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sbd_sync_state_t;

  sbd_sync_state_t s_q;
  sbd_sync_state_t s_d;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // A bit only moves once stages two and three agree, so a bit caught mid-change is ignored
  always_comb begin
    s_d = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.q = (~(s_q.s2 ^ s_q.s3) & s_q.s2) | ((s_q.s2 ^ s_q.s3) & s_q.q);
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.q;

endmodule

// ### logic/sbd_decode.sv
// Address decode of the four slave-code bits and the alignment check
`timescale 1ns/1ns
module sbd_decode
  import sbd_pkg::*;
(
  input wire logic [sbd_pkg::ADDR_W-1:0] addr,
  input wire sbd_pkg::sbd_size_t size,
  output sbd_pkg::sbd_slave_t slave,
  output logic alt_map,
  output logic err
);

  // ==========================================================================
  // Slave selection
  // ==========================================================================
  // top bits pick slave
  always_comb begin
    slave = SLV_NONE;
    alt_map = 1'b0;
    case (addr[CODE_HI:CODE_LO])
      CODE_OCD: slave = SLV_OCD;
      CODE_HSB: slave = SLV_HSB;
      CODE_HSB_ALT: begin
        slave = SLV_HSB;
        alt_map = 1'b1;
      end
      CODE_MSU: slave = SLV_MSU;
      default: slave = SLV_NONE;
    endcase
    err = (slave == SLV_NONE) || !sbd_aligned(size, addr[1:0]);
  end

endmodule

// ### logic/sbd_bus_master.sv
// What this block does
// - Every access carries a 36-bit address reaching any slave on the bus.
// - Byte, halfword and word accesses are supported.
// - Address bits 35 to 32 pick the slave and the low 32 bits go to that slave.
// - Code 0x4 reaches the high-speed system bus exactly as the processor sees it.
// - Code 0x5 is a second mapping of the same high-speed system bus space.
// - Code 0x6 reaches the memory service unit registers.
// - Code 0x1 reaches the on-chip debug registers, 0x0 is unallocated, others reserved.
// - The debugger side may run at any frequency relative to the chip clock.
// - An access waits and does not complete while the system clock is stopped.
// - Debugger activity requests the system clock back without leaving sleep.
// - One bus master serves both the JTAG port and the single-wire port.
// - Transfers are synchronised from the debugger domain into the bus domain.
// - Flash and fuses are programmed through the system bus like the processor does.
`timescale 1ns/1ns
module sbd_bus_master
  import sbd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic jtag_tck,
  input wire sbd_pkg::sbd_dbg_req_t jtag_req,
  output sbd_pkg::sbd_dbg_rsp_t jtag_rsp,
  input wire logic swd_clk,
  input wire sbd_pkg::sbd_dbg_req_t swd_req,
  output sbd_pkg::sbd_dbg_rsp_t swd_rsp,
  input wire logic sys_clk_on,
  output logic sys_clk_req,
  output sbd_pkg::sbd_slv_req_t slv_req,
  input wire sbd_pkg::sbd_slv_rsp_t ocd_rsp,
  input wire sbd_pkg::sbd_slv_rsp_t hsb_rsp,
  input wire sbd_pkg::sbd_slv_rsp_t msu_rsp
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    sbd_state_t st;
    logic port;
    sbd_dbg_req_t cur;
    logic [N_PORTS-1:0] seen;
    logic [N_PORTS-1:0] lclk_prev;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic wake;
    sbd_slv_req_t slv;
    sbd_dbg_rsp_t [N_PORTS-1:0] rsp;
  } sbd_bm_state_t;

  sbd_bm_state_t s_q;
  sbd_bm_state_t s_d;

  logic [SYNC_W-1:0] jtag_sync;
  logic [SYNC_W-1:0] swd_sync;
  sbd_dbg_req_t [N_PORTS-1:0] req_s;
  logic [N_PORTS-1:0] lclk_s;
  logic [N_PORTS-1:0] pend;
  logic [N_PORTS-1:0] lclk_edge;
  sbd_slave_t dec_slave;
  logic dec_alt;
  logic dec_err;
  sbd_slv_rsp_t sel_rsp;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Answer word of a finished access; the toggle moves in the same update as
  // err and data, so a debugger that sees the toggle never reads half an answer
  function automatic sbd_dbg_rsp_t sbd_answer(input sbd_dbg_rsp_t prev, input logic err,
    input logic [DATA_W-1:0] data);
    sbd_answer.ack_tgl = ~prev.ack_tgl;
    sbd_answer.err = err;
    sbd_answer.rdata = data;
  endfunction

  // Slave request for a decoded access; a slave only ever sees the low address word
  function automatic sbd_slv_req_t sbd_launch(input sbd_dbg_req_t r, input sbd_slave_t slave,
    input logic alt);
    sbd_launch = '0;
    sbd_launch.addr = r.addr[SLV_ADDR_W-1:0];
    sbd_launch.sel[SEL_OCD] = (slave == SLV_OCD);
    sbd_launch.sel[SEL_HSB] = (slave == SLV_HSB);
    sbd_launch.sel[SEL_MSU] = (slave == SLV_MSU);
    sbd_launch.alt_map = alt;
    sbd_launch.size = r.size;
    sbd_launch.be = sbd_byte_en(r.size, r.addr[1:0]);
    sbd_launch.write = r.write;
    sbd_launch.wdata = r.wdata;
    sbd_launch.valid = 1'b1;
  endfunction

  // Slave request with strobe and selects dropped; address and data stay to keep the bus quiet
  function automatic sbd_slv_req_t sbd_release(input sbd_slv_req_t cur);
    sbd_release = cur;
    sbd_release.valid = 1'b0;
    sbd_release.sel = '0;
  endfunction

  // ==========================================================================
  // Crossing from the debugger side
  // ==========================================================================
  // sync debugger inputs
  // The request word is set up before its toggle flips, so it has settled
  // by the time the filtered toggle shows the change; no clock ratio is assumed.
  // any link rate
  sbd_sync #(
    .W(SYNC_W)
  ) u_jtag_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({jtag_tck, jtag_req}),
    .q(jtag_sync)
  );

  sbd_sync #(
    .W(SYNC_W)
  ) u_swd_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({swd_clk, swd_req}),
    .q(swd_sync)
  );

  // Unpack synchronised words
  always_comb begin
    req_s[PORT_JTAG] = sbd_dbg_req_t'(jtag_sync[REQ_W-1:0]);
    req_s[PORT_SWD] = sbd_dbg_req_t'(swd_sync[REQ_W-1:0]);
    lclk_s[PORT_JTAG] = jtag_sync[REQ_W];
    lclk_s[PORT_SWD] = swd_sync[REQ_W];
  end

  // ==========================================================================
  // Decode of the held request
  // ==========================================================================
  // slave-code and low alignment bits decoded
  sbd_decode u_decode (
    .addr(s_q.cur.addr),
    .size(s_q.cur.size),
    .slave(dec_slave),
    .alt_map(dec_alt),
    .err(dec_err)
  );

  // Answer of the slave that is currently selected
  always_comb begin
    sel_rsp = '0;
    if (s_q.slv.sel[SEL_OCD]) begin
      sel_rsp = ocd_rsp;
    end else if (s_q.slv.sel[SEL_HSB]) begin
      sel_rsp = hsb_rsp;
    end else if (s_q.slv.sel[SEL_MSU]) begin
      sel_rsp = msu_rsp;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_d = s_q;

    for (int p = 0; p < N_PORTS; p++) begin
      pend[p] = (req_s[p].req_tgl != s_q.seen[p]);
      lclk_edge[p] = (lclk_s[p] != s_q.lclk_prev[p]);
    end
    s_d.lclk_prev = lclk_s;

    // activity wakes clock
    // Only the clock request is raised; the sleep state itself is left alone,
    // so the device stays asleep while its clock serves the debugger.
    if ((|lclk_edge) || (|pend) || (s_q.st != ST_IDLE)) begin
      s_d.wake_cnt = WAKE_HOLD_CNT;
    end else if (s_q.wake_cnt != '0) begin
      s_d.wake_cnt = s_q.wake_cnt - 1'b1;
    end
    s_d.wake = (s_d.wake_cnt != '0);

    case (s_q.st)
      ST_IDLE: begin
        if (|pend) begin
          if (pend[PORT_JTAG] && pend[PORT_SWD]) begin
            s_d.port = ~s_q.port;
          end else begin
            s_d.port = pend[PORT_SWD];
          end
          s_d.cur = req_s[s_d.port];
          s_d.st = ST_WAIT_CLK;
        end
      end

      ST_WAIT_CLK: begin
        if (sys_clk_on) begin
          if (dec_err) begin
            s_d.seen[s_q.port] = s_q.cur.req_tgl;
            s_d.rsp[s_q.port] = sbd_answer(s_q.rsp[s_q.port], 1'b1, '0);
            s_d.st = ST_IDLE;
          end else begin
            s_d.slv = sbd_launch(s_q.cur, dec_slave, dec_alt);
            s_d.st = ST_ACCESS;
          end
        end
      end

      ST_ACCESS: begin
        // complete only clocked
        // A slave answer is taken only while the system clock is reported on.
        if (sel_rsp.ready && sys_clk_on) begin
          s_d.seen[s_q.port] = s_q.cur.req_tgl;
          s_d.rsp[s_q.port] = sbd_answer(s_q.rsp[s_q.port], sel_rsp.err, s_q.slv.write ? '0 : sel_rsp.rdata);
          s_d.slv = sbd_release(s_q.slv);
          s_d.st = ST_IDLE;
        end
      end

      default: begin
        s_d.st = ST_IDLE;
        s_d.slv = sbd_release(s_q.slv);
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  // ==========================================================================
  assign jtag_rsp = s_q.rsp[PORT_JTAG];
  assign swd_rsp = s_q.rsp[PORT_SWD];
  assign slv_req = s_q.slv;
  assign sys_clk_req = s_q.wake;

endmodule

// ### verif/sbd_bus_master_props.sv
// Port assertions for the service access bus master
`timescale 1ns/1ns
module sbd_bus_master_props
  import sbd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic jtag_tck,
  input wire sbd_pkg::sbd_dbg_req_t jtag_req,
  input wire sbd_pkg::sbd_dbg_rsp_t jtag_rsp,
  input wire logic swd_clk,
  input wire sbd_pkg::sbd_dbg_req_t swd_req,
  input wire sbd_pkg::sbd_dbg_rsp_t swd_rsp,
  input wire logic sys_clk_on,
  input wire logic sys_clk_req,
  input wire sbd_pkg::sbd_slv_req_t slv_req,
  input wire sbd_pkg::sbd_slv_rsp_t ocd_rsp,
  input wire sbd_pkg::sbd_slv_rsp_t hsb_rsp,
  input wire sbd_pkg::sbd_slv_rsp_t msu_rsp
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Ready of all three slaves in select-bit order; ready from unselected ones means nothing
  logic [2:0] rdy_vec;
  assign rdy_vec = {msu_rsp.ready, hsb_rsp.ready, ocd_rsp.ready};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_onehot; slv_req.valid |-> $onehot(slv_req.sel); endproperty
  a_onehot: assert property (p_onehot) else $error("slave select not one-hot");
  property p_legal;
    slv_req.valid |-> slv_req.size != SZ_RSVD && !(slv_req.size == SZ_HALF && slv_req.addr[0])
      && !(slv_req.size == SZ_WORD && slv_req.addr[1:0] != 2'h0);
  endproperty
  a_legal: assert property (p_legal) else $error("illegal access reached a slave");
  property p_be;
    slv_req.valid |-> slv_req.be == (slv_req.size == SZ_WORD ? 4'hf : slv_req.size == SZ_HALF ?
      (slv_req.addr[1] ? 4'hc : 4'h3) : 4'h1 << slv_req.addr[1:0]);
  endproperty
  a_be: assert property (p_be) else $error("byte enables do not match size");
  property p_alt; slv_req.valid && !slv_req.sel[SEL_HSB] |-> !slv_req.alt_map; endproperty
  a_alt: assert property (p_alt) else $error("alias flag outside system bus");
  // A request stands until a ready seen with the clock running
  property p_hold;
    slv_req.valid && !(sys_clk_on && |(slv_req.sel & rdy_vec)) |=> slv_req.valid && $stable(slv_req);
  endproperty
  a_hold: assert property (p_hold) else $error("slave request dropped early");
  property p_release; slv_req.valid && sys_clk_on && |(slv_req.sel & rdy_vec) |=> !slv_req.valid; endproperty
  a_release: assert property (p_release) else $error("slave request not released");
  property p_wake; slv_req.valid |-> sys_clk_req; endproperty
  a_wake: assert property (p_wake) else $error("clock not requested while busy");
  property p_tck; $rose(jtag_tck) |-> ##[1:8] sys_clk_req; endproperty
  a_tck: assert property (p_tck) else $error("link activity did not request clock");
  property p_errzero; $changed(jtag_rsp.ack_tgl) && jtag_rsp.err |-> jtag_rsp.rdata == 32'h0; endproperty
  a_errzero: assert property (p_errzero) else $error("error answer carries data");
  property p_stand;
    $stable(jtag_rsp.ack_tgl) && $stable(swd_rsp.ack_tgl) |-> $stable(jtag_rsp) && $stable(swd_rsp);
  endproperty
  a_stand: assert property (p_stand) else $error("answer changed without completion");
  c_alt: cover property (slv_req.valid && slv_req.alt_map);
  c_msu: cover property (slv_req.valid && slv_req.sel[SEL_MSU]);
  c_err: cover property ($changed(swd_rsp.ack_tgl) && swd_rsp.err);
  c_hold: cover property (slv_req.valid && !sys_clk_on && |(slv_req.sel & rdy_vec));
endmodule
bind sbd_bus_master sbd_bus_master_props u_props (.clk(clk), .arst_n(arst_n), .jtag_tck(jtag_tck),
  .jtag_req(jtag_req), .jtag_rsp(jtag_rsp), .swd_clk(swd_clk), .swd_req(swd_req), .swd_rsp(swd_rsp),
  .sys_clk_on(sys_clk_on), .sys_clk_req(sys_clk_req), .slv_req(slv_req), .ocd_rsp(ocd_rsp),
  .hsb_rsp(hsb_rsp), .msu_rsp(msu_rsp));

// ### verif/sbd_dbg_model.sv
// Behavioural debugger port: toggle handshake plus a link clock
`timescale 1ns/1ns
module sbd_dbg_model
  import sbd_pkg::*;
(
  input wire logic go,
  input wire sbd_pkg::sbd_dbg_req_t cmd,
  input wire sbd_pkg::sbd_dbg_rsp_t rsp,
  output sbd_pkg::sbd_dbg_req_t req,
  output logic link_clk,
  output logic busy
);
  initial begin
    req = '0;
    link_clk = 1'b0;
    busy = 1'b0;
  end
  // One request at a time; fields settle before the toggle flips
  always @(posedge go) begin
    busy = 1'b1;
    // aligned unless the bench asks otherwise
    req.write = cmd.write;
    req.size = cmd.size;
    req.addr = cmd.addr;
    req.wdata = cmd.wdata;
    #110; // Keeps the toggle flip and later pin changes off the bus clock edge
    req.req_tgl = ~req.req_tgl;
    // link clock runs only while a request is open
    while (rsp.ack_tgl !== req.req_tgl) begin
      #200;
      link_clk = ~link_clk;
    end
    link_clk = 1'b0;
    // Answered fields are stale now, so show something else
    req.addr = ~req.addr;
    req.wdata = ~req.wdata;
    busy = 1'b0;
  end
endmodule

// ### verif/tb_sbd_bus_master.sv
// Self-checking bench for the service access bus master
`timescale 1ns/1ns
module tb_sbd_bus_master;
  import sbd_pkg::*;
  logic clk, arst_n, sys_clk_on, sys_clk_req, rdy;
  logic go [2];
  logic bsy [2];
  logic lck [2];
  sbd_dbg_req_t cmd [2];
  sbd_dbg_req_t req [2];
  sbd_dbg_rsp_t rsp [2];
  sbd_slv_req_t slv_req;
  sbd_slv_rsp_t ocd_rsp, hsb_rsp, msu_rsp;
  int cnt, lat, err_count, comparisons;
  logic [32:0] last_wr;

  sbd_bus_master dut (.clk(clk), .arst_n(arst_n), .jtag_tck(lck[0]), .jtag_req(req[0]), .jtag_rsp(rsp[0]),
    .swd_clk(lck[1]), .swd_req(req[1]), .swd_rsp(rsp[1]), .sys_clk_on(sys_clk_on), .sys_clk_req(sys_clk_req),
    .slv_req(slv_req), .ocd_rsp(ocd_rsp), .hsb_rsp(hsb_rsp), .msu_rsp(msu_rsp));
  sbd_dbg_model u_jtag (.go(go[0]), .cmd(cmd[0]), .rsp(rsp[0]), .req(req[0]), .link_clk(lck[0]), .busy(bsy[0]));
  sbd_dbg_model u_swd (.go(go[1]), .cmd(cmd[1]), .rsp(rsp[1]), .req(req[1]), .link_clk(lck[1]), .busy(bsy[1]));

  // ==========================================================================
  // Slaves: each answers with its address mixed with its own mark
  // ==========================================================================
  // Ready also pulses while the clock is off; the design must ignore it
  always @(posedge clk) begin
    rdy <= slv_req.valid && !rdy && cnt >= lat;
    cnt <= slv_req.valid ? cnt + 1 : 0;
    if (slv_req.valid) begin
      last_wr <= {slv_req.write, slv_req.wdata};
    end
  end
  assign ocd_rsp = {rdy & slv_req.sel[SEL_OCD], 1'b0, slv_req.addr ^ 32'h5a5a_0000};
  assign hsb_rsp = {rdy & slv_req.sel[SEL_HSB], 1'b0, slv_req.addr ^ 32'h5a5a_0001 ^ {slv_req.alt_map, 31'h0}};
  assign msu_rsp = {rdy & slv_req.sel[SEL_MSU], 1'b0, slv_req.addr ^ 32'h5a5a_0002};

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic bad(input sbd_size_t s, input logic [35:0] a);
    bad = !(a[35:32] inside {4'h1, 4'h4, 4'h5, 4'h6}) || s == SZ_RSVD || (s == SZ_HALF && a[0])
      || (s == SZ_WORD && a[1:0] != 2'h0);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [35:0] a);
    case (a[35:32])
      4'h1: exp_rd = a[31:0] ^ 32'h5a5a_0000;
      4'h4: exp_rd = a[31:0] ^ 32'h5a5a_0001;
      4'h5: exp_rd = a[31:0] ^ 32'hda5a_0001;
      default: exp_rd = a[31:0] ^ 32'h5a5a_0002;
    endcase
  endfunction
  task automatic launch(input int p, input logic w, input sbd_size_t s, input logic [35:0] a);
    cmd[p] <= '{req_tgl: 1'b0, write: w, size: s, addr: a, wdata: 32'hc3a5_0f1e};
    go[p] <= 1'b1;
  endtask
  task automatic finish(input int p, input logic w, input sbd_size_t s, input logic [35:0] a);
    int n;
    n = 0;
    while (bsy[p] && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("done", bsy[p], 0);
    chk("err", rsp[p].err, bad(s, a));
    chk("rdata", rsp[p].rdata, (w || bad(s, a)) ? 32'h0 : exp_rd(a));
    if (!bad(s, a)) begin
      chk("slave write", last_wr, {w, 32'hc3a5_0f1e});
    end
  endtask
  task automatic acc(input int p, input logic w, input sbd_size_t s, input logic [35:0] a);
    launch(p, w, s, a);
    @(posedge clk);
    go[p] <= 1'b0;
    finish(p, w, s, a);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_codes();
    for (int c = 0; c < 16; c++) begin
      acc(PORT_JTAG, 1'b0, SZ_WORD, {c[3:0], 32'h8012_3454});
    end
    acc(PORT_JTAG, 1'b1, SZ_WORD, 36'h5_0000_0010);
    $display("test codes done");
  endtask
  task automatic t_sizes();
    sbd_size_t sz [6] = '{SZ_BYTE, SZ_HALF, SZ_HALF, SZ_WORD, SZ_RSVD, SZ_BYTE};
    logic [1:0] lo [6] = '{2'h3, 2'h2, 2'h1, 2'h2, 2'h0, 2'h1};
    lat = 4;
    for (int k = 0; k < 6; k++) begin
      acc(PORT_SWD, k[0], sz[k], {4'h6, 30'h0400_0c00, lo[k]});
    end
    $display("test sizes done");
  endtask
  task automatic t_ports();
    lat = 2;
    launch(PORT_JTAG, 1'b0, SZ_HALF, 36'h4_1000_0002);
    launch(PORT_SWD, 1'b0, SZ_BYTE, 36'h1_0000_0105);
    @(posedge clk);
    go[0] <= 1'b0;
    go[1] <= 1'b0;
    finish(PORT_JTAG, 1'b0, SZ_HALF, 36'h4_1000_0002);
    finish(PORT_SWD, 1'b0, SZ_BYTE, 36'h1_0000_0105);
    $display("test ports done");
  endtask
  task automatic t_clk_off();
    repeat (60) @(posedge clk);
    chk("clock idle", sys_clk_req, 0);
    sys_clk_on <= 1'b0;
    launch(PORT_JTAG, 1'b0, SZ_WORD, 36'h4_0000_0200);
    @(posedge clk);
    go[0] <= 1'b0;
    repeat (60) @(posedge clk);
    chk("pending", bsy[0], 1);
    chk("clock request", sys_clk_req, 1);
    sys_clk_on <= 1'b1;
    finish(PORT_JTAG, 1'b0, SZ_WORD, 36'h4_0000_0200);
    // Clock stops while the slave is being asked, so its ready pulses must be ignored
    lat = 0;
    launch(PORT_JTAG, 1'b0, SZ_WORD, 36'h1_0000_0300);
    @(posedge clk);
    go[0] <= 1'b0;
    while (!slv_req.valid) begin
      @(posedge clk);
    end
    sys_clk_on <= 1'b0;
    repeat (20) @(posedge clk);
    chk("held", {bsy[0], slv_req.valid}, 2'h3);
    sys_clk_on <= 1'b1;
    finish(PORT_JTAG, 1'b0, SZ_WORD, 36'h1_0000_0300);
    $display("test clock off done");
  endtask

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog: the scenarios need a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    arst_n = 1'b0;
    sys_clk_on = 1'b1;
    go = '{1'b0, 1'b0};
    cmd = '{'0, '0};
    lat = 0;
    cnt = 0;
    rdy = 1'b0;
    err_count = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_codes();
    t_sizes();
    t_ports();
    t_clk_off();
    end_of_test();
  end
endmodule
